// ===== hw/setting_group_selector.sv
/*
 * Setting group selector: chooses one of eight setting groups from
 * request inputs and a forced override (a remote request, raised only under override, never selects), and reports
 * the active group and selection failures as interrupt events.
 * Assumes request inputs synchronous to i_core_clk and a register master
 * that drives one-cycle strobes and takes read data one cycle later.
 */
`timescale 1ns/1ps
// Contract
// R01: Eight groups; reset enables and activates group one.
// R02: More groups enabled lets requests steer selection.
// R03: Override set ignores requests; only forcing decides.
// R04: Requests accept pulses or static levels.
// R05: Simultaneous requests: lowest numbered group wins.
// R06: Two held levels: higher priority stays active.
// R07: Pulse-selected group stays until another request.
// R08: Forcing needs enabled target and override set.
// R09: Clearing override resumes automatic selection immediately.
// R10: Readable active group, group one after reset.
// R11: Force choice none or group; acts as pulse.
// R12: Last forced group remains after override clears.
// R13: Override resets off, gates changes, stays until cleared.
// R14: Used groups enables one through N, defaults loaded.
// R15: Remote request blocked by higher held request.
// R16: Held level blocks all lower priority requests.
// R17: Events on unconfigured and lost-priority requests.
// R18: Active group changes only at cycle boundary.
module setting_group_selector
    import group_sel_pkg::*;
(
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst,
    input  wire logic [NUM_GROUPS-1:0] i_group_req,
    input  wire logic [ADDR_W-1:0]     i_addr,
    input  wire logic [DATA_W-1:0]     i_wr_data,
    input  wire logic                  i_wr_en,
    input  wire logic                  i_rd_en,
    output logic      [DATA_W-1:0]     o_rd_data,
    output logic      [NUM_GROUPS-1:0] o_group_active,
    output logic      [3:0]            o_active_group,
    output logic      [NUM_GROUPS-1:0] o_load_defaults,
    output logic                       o_irq
);

    // ==========================================================
    // Register state
    logic                  override_q;
    logic [2:0]            used_q;
    logic [3:0]            force_sel_q;
    logic [3:0]            remote_sel_q;
    logic [2:0]            active_q;
    logic [2:0]            active_d;
    logic [NUM_GROUPS-1:0] req_prev_q;
    logic [NUM_EVENTS-1:0] irq_stat_q;
    logic [NUM_EVENTS-1:0] irq_mask_q;
    logic [DATA_W-1:0]     rd_data_q;
    logic [NUM_GROUPS-1:0] enabled_q;
    logic [NUM_GROUPS-1:0] load_q;
    logic                  nocfg_q;
    logic                  lowpri_q;

    logic                  wr_ctrl;
    logic                  wr_force;
    logic                  wr_remote;
    logic [NUM_GROUPS-1:0] enabled_d;
    logic [NUM_GROUPS-1:0] held;
    logic [NUM_GROUPS-1:0] remote_vec;
    logic [NUM_GROUPS-1:0] req_all;
    logic [NUM_GROUPS-1:0] req_ok;
    logic                  hold_any;
    logic [2:0]            hold_idx;
    logic [NUM_GROUPS-1:0] hold_below;
    logic                  win_any;
    logic [2:0]            win_idx;
    logic [NUM_GROUPS-1:0] win_below;
    logic [3:0]            wr_sel;
    logic                  force_try;
    logic                  force_ok;
    logic                  nocfg_now;
    logic                  lowpri_now;
    logic [NUM_EVENTS-1:0] ev_set;

    // ==========================================================
    // Register decode
    assign wr_ctrl   = i_wr_en && (i_addr == OFS_CTRL);
    assign wr_force  = i_wr_en && (i_addr == OFS_FORCE);
    assign wr_remote = i_wr_en && (i_addr == OFS_REMOTE);
    assign wr_sel    = i_wr_data[3:0];

    // Override stays until software clears it.
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            override_q <= 1'b0; // R13
            used_q     <= USED_RST; // R14
        end
        else if (wr_ctrl)
        begin
            override_q <= i_wr_data[CTRL_OVR_BIT]; // R13
            used_q     <= i_wr_data[CTRL_USED_LSB +: 3]; // R14
        end
    end

    // Force and remote choices are stored for readback; values above 8 read as none.
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            force_sel_q  <= SEL_NONE; // R11
            remote_sel_q <= SEL_NONE; // R15
        end
        else
        begin
            if (wr_force)
            begin
                force_sel_q <= (wr_sel > 4'h8) ? SEL_NONE : wr_sel; // R11
            end
            if (wr_remote)
            begin
                remote_sel_q <= (wr_sel > 4'h8) ? SEL_NONE : wr_sel; // R15
            end
        end
    end

    // ==========================================================
    // Enabled groups: one through N.
    always_comb
    begin
        enabled_d = '0;
        for (int k = 0; k < NUM_GROUPS; k++)
        begin
            enabled_d[k] = (k <= int'(used_q)); // R14
        end
    end

    // Newly enabled groups get a one-cycle default load pulse.
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            enabled_q <= 8'h01; // R01
            load_q    <= '0;
        end
        else
        begin
            enabled_q <= enabled_d;
            load_q    <= enabled_d & ~enabled_q; // R14
        end
    end

    // ==========================================================
    // Request evaluation
    // A level counts as held once it has stayed high for two samples; a
    // pulse is still a request in its first cycle.
    assign held = i_group_req & req_prev_q & enabled_q; // R04 R06

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            req_prev_q <= '0;
        end
        else
        begin
            req_prev_q <= i_group_req;
        end
    end

    // A remote write is a one-shot request, only while override is set.
    always_comb
    begin
        remote_vec = '0;
        if (wr_remote && override_q && wr_sel != SEL_NONE && wr_sel <= 4'h8)
        begin
            remote_vec[wr_sel[2:0] - 3'h1] = 1'b1; // R13 R15
        end
    end

    assign req_all = (i_group_req | remote_vec) & enabled_q;

    low_first #(.W(NUM_GROUPS), .IW(3)) u_hold (
        .i_vec   (held),
        .o_any   (hold_any),
        .o_idx   (hold_idx),
        .o_above (hold_below)
    );

    // Requests below the highest held group are dropped.
    assign req_ok = hold_any ? (req_all & ~hold_below) : req_all; // R16 R15

    low_first #(.W(NUM_GROUPS), .IW(3)) u_win (
        .i_vec   (req_ok),
        .o_any   (win_any),
        .o_idx   (win_idx),
        .o_above (win_below)
    );

    // Forcing needs override set and an enabled target.
    assign force_try = wr_force && wr_sel != SEL_NONE;
    assign force_ok  = force_try && override_q && wr_sel <= 4'h8 && enabled_q[wr_sel[2:0] - 3'h1]; // R08

    // ==========================================================
    // Active group selection
    always_comb
    begin
        active_d = active_q; // R07 R12
        if (override_q)
        begin
            if (force_ok)
            begin
                active_d = wr_sel[2:0] - 3'h1; // R03 R11
            end
        end
        else if (win_any)
        begin
            active_d = win_idx; // R02 R05 R06 R09
        end
        if (!enabled_q[active_d])
        begin
            active_d = ACTIVE_RST;
        end
    end

    // Registered so exactly one group is active between boundaries.
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            active_q <= ACTIVE_RST; // R01
        end
        else
        begin
            active_q <= active_d; // R18
        end
    end

    always_comb
    begin
        o_group_active = '0;
        o_group_active[active_q] = 1'b1; // R10
    end

    assign o_active_group  = {1'b0, active_q} + 4'h1; // R10
    assign o_load_defaults = load_q;

    // ==========================================================
    // Failure conditions and events
    assign nocfg_now  = !override_q && |(i_group_req & ~enabled_q); // R17
    assign lowpri_now = !override_q && |(req_all & (win_below | (hold_any ? hold_below : '0))); // R17

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            nocfg_q  <= 1'b0;
            lowpri_q <= 1'b0;
        end
        else
        begin
            nocfg_q  <= nocfg_now;
            lowpri_q <= lowpri_now;
        end
    end

    always_comb
    begin
        ev_set                = '0;
        ev_set[EV_NOCFG_ON]   = nocfg_now && !nocfg_q; // R17
        ev_set[EV_NOCFG_OFF]  = !nocfg_now && nocfg_q; // R17
        ev_set[EV_LOWPRI_ON]  = lowpri_now && !lowpri_q; // R17
        ev_set[EV_LOWPRI_OFF] = !lowpri_now && lowpri_q; // R17
        ev_set[EV_FORCE_FAIL] = force_try && !force_ok; // R08
        ev_set[EV_FORCE_OK]   = force_ok;
        ev_set[EV_ACT_CHANGE] = active_d != active_q;
        ev_set[EV_NEW_GROUPS] = |(enabled_d & ~enabled_q);
    end

    // A new event wins over a clear in the same cycle.
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            irq_stat_q <= '0;
            irq_mask_q <= MASK_RST;
        end
        else
        begin
            if (i_wr_en && i_addr == OFS_IRQ_MASK)
            begin
                irq_mask_q <= i_wr_data[NUM_EVENTS-1:0];
            end
            if (i_wr_en && i_addr == OFS_IRQ_STAT)
            begin
                irq_stat_q <= (irq_stat_q & ~i_wr_data[NUM_EVENTS-1:0]) | ev_set;
            end
            else
            begin
                irq_stat_q <= irq_stat_q | ev_set;
            end
        end
    end

    assign o_irq = |(irq_stat_q & irq_mask_q);

    // ==========================================================
    // Read port: data valid the cycle after the strobe, unmapped reads zero.
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            rd_data_q <= '0;
        end
        else if (i_rd_en)
        begin
            case (i_addr)
                OFS_CTRL:     rd_data_q <= {25'h0, used_q, 3'h0, override_q};
                OFS_FORCE:    rd_data_q <= {28'h0, force_sel_q};
                OFS_REMOTE:   rd_data_q <= {28'h0, remote_sel_q};
                OFS_STATE:    rd_data_q <= {8'h0, held, enabled_q, 4'h0, o_active_group}; // R10
                OFS_IRQ_STAT: rd_data_q <= {24'h0, irq_stat_q};
                OFS_IRQ_MASK: rd_data_q <= {24'h0, irq_mask_q};
                default:      rd_data_q <= '0;
            endcase
        end
        else
        begin
            rd_data_q <= '0;
        end
    end

    assign o_rd_data = rd_data_q;

    // ==========================================================
    // Checks
    reset_state_a: assert property (@(posedge i_core_clk) i_rst |=> // R01
        (active_q == 3'h0 && !override_q && enabled_q == 8'h01))
        else $error("reset state wrong");
    override_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // R03
        (override_q && !force_ok && enabled_q[active_q]) |=> $stable(active_q))
        else $error("active group moved under override");
    priority_pick_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // R05
        (!override_q && win_any && !i_wr_en) |=> (active_q == $past(win_idx) &&
        $past(req_ok[win_idx] && (req_ok & ((8'h01 << win_idx) - 8'h01)) == 8'h00)))
        else $error("lower priority request won");
    pulse_keep_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // R07
        (!override_q && req_ok == 8'h00 && enabled_q[active_q]) |=> $stable(active_q))
        else $error("active group dropped without request");
    force_take_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // R08
        force_ok |=> (o_active_group == $past(wr_sel)))
        else $error("accepted force not applied");
    force_reject_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // R08
        (force_try && !override_q && !win_any) |=>
        (irq_stat_q[EV_FORCE_FAIL] && $stable(active_q) || !$past(enabled_q[active_q])))
        else $error("force without override accepted");
    held_block_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // R16
        (!override_q && held[0]) |=> (active_q == 3'h0))
        else $error("held group one was overruled");
    one_active_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // R18
        $onehot(o_group_active) && enabled_q[active_q] || $past(wr_ctrl, 2))
        else $error("active group not unique or not enabled");
    event_sticky_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // R17
        (ev_set != 8'h00) |=> ((irq_stat_q & $past(ev_set)) == $past(ev_set)))
        else $error("event lost against a clear");
    resume_auto_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // R09
        ($fell(override_q) && hold_any) |=> (active_q == $past(win_idx) && active_q <= $past(hold_idx)))
        else $error("automatic selection not resumed");

endmodule

// ===== hw/group_sel_pkg.sv
/*
 * Constants shared by the setting group selector: register offsets,
 * field positions, reset values and event bit positions.
 * Assumes a single 20 MHz core clock and a plain strobe register port.
 */
package group_sel_pkg;

    // ==========================================================
    // Sizes
    localparam int          NUM_GROUPS     = 8;
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 32;
    localparam int          NUM_EVENTS     = 8;

    // ==========================================================
    // Register offsets (byte addresses, one word each)
    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_FORCE      = 8'h04;
    localparam logic [7:0]  OFS_REMOTE     = 8'h08;
    localparam logic [7:0]  OFS_STATE      = 8'h0C;
    localparam logic [7:0]  OFS_IRQ_STAT   = 8'h10;
    localparam logic [7:0]  OFS_IRQ_MASK   = 8'h14;

    // ==========================================================
    // Field positions
    localparam int          CTRL_OVR_BIT   = 0;
    localparam int          CTRL_USED_LSB  = 4;
    localparam int          STATE_EN_LSB   = 8;
    localparam int          STATE_HOLD_LSB = 16;

    // ==========================================================
    // Reset values
    localparam logic [2:0]  USED_RST       = 3'h0;
    localparam logic [2:0]  ACTIVE_RST     = 3'h0;
    localparam logic [3:0]  SEL_NONE       = 4'h0;
    localparam logic [7:0]  MASK_RST       = 8'h00;

    // ==========================================================
    // Event bits in the interrupt status register
    localparam int          EV_NOCFG_ON    = 0;
    localparam int          EV_NOCFG_OFF   = 1;
    localparam int          EV_LOWPRI_ON   = 2;
    localparam int          EV_LOWPRI_OFF  = 3;
    localparam int          EV_FORCE_FAIL  = 4;
    localparam int          EV_FORCE_OK    = 5;
    localparam int          EV_ACT_CHANGE  = 6;
    localparam int          EV_NEW_GROUPS  = 7;

endpackage

// ===== hw/low_first.sv
/*
 * Finds the lowest set bit of a vector, which is the request of
 * highest priority. Purely combinational; no assumptions on context.
 */
`timescale 1ns/1ps
module low_first #(
    parameter int W  = 8,
    parameter int IW = 3
) (
    input  wire logic [W-1:0]  i_vec,
    output logic               o_any,
    output logic [IW-1:0]      o_idx,
    output logic [W-1:0]       o_above
);
    // o_above marks every bit of lower priority than the winner.
    always_comb
    begin
        o_any   = 1'b0;
        o_idx   = '0;
        o_above = '0;
        for (int k = W - 1; k >= 0; k--)
        begin
            if (i_vec[k])
            begin
                o_any   = 1'b1;
                o_idx   = IW'(k);
                o_above = ~((W'(2) << k) - W'(1));
            end
        end
    end
endmodule

// ===== bench/req_source.sv
/*
 * Model of the request sources beside the selector: internal logic
 * outputs and digital inputs, each showing a pulse or a held level.
 * Assumes the bench sets its commands by non-blocking assignment
 * right after a rising edge of the same clock.
 */
`timescale 1ns/1ps
module req_source (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_pulse,
    input  wire logic [7:0] i_level,
    output logic      [7:0] o_group_req
);
    // ==========================================================
    // Request drive
    // Registered so that a request never changes near the sampling edge.
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
            o_group_req <= 8'h00;
        else
            o_group_req <= i_pulse | i_level;
    end
endmodule

// ===== bench/setting_group_selector_bench.sv
/*
 * Self-checking bench for the setting group selector: register tasks
 * on the strobe port and scenarios with expected values.
 * Assumes the design package and the request source model are compiled first.
 */
`timescale 1ns/1ps
module setting_group_selector_bench
    import group_sel_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  pls = 8'h00;
    logic [7:0]  lvl = 8'h00;
    logic [7:0]  req;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [31:0] rdata;
    logic [7:0]  grp_act;
    logic [3:0]  act_code;
    logic [7:0]  ld;
    logic [7:0]  ld_seen = 8'h00;
    logic        irq;
    int          err_total = 0;
    int          n_compared = 0;

    always #25 clk = ~clk;

    req_source req_source_inst (.i_core_clk(clk), .i_rst(rst), .i_pulse(pls), .i_level(lvl), .o_group_req(req));

    setting_group_selector setting_group_selector_inst (
        .i_core_clk(clk), .i_rst(rst), .i_group_req(req), .i_addr(addr), .i_wr_data(wdata),
        .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rdata), .o_group_active(grp_act),
        .o_active_group(act_code), .o_load_defaults(ld), .o_irq(irq));

    // Default loads are one-cycle pulses, so they are gathered rather than sampled.
    always @(posedge clk)
    begin
        if (rst)
            ld_seen <= 8'h00;
        else
            ld_seen <= ld_seen | ld;
    end

    // ==========================================================
    // Helpers
    task automatic give_verdict;
        $display("Comparisons %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string what);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        check(what, rdata & m, e);
        @(posedge clk);
    endtask

    task automatic stat(input int b);
        rchk(OFS_IRQ_STAT, 32'h1 << b, 32'h1 << b, "status bit");
    endtask

    task automatic pulse(input logic [7:0] v);
        pls <= v;
        @(posedge clk);
        pls <= 8'h00;
        @(posedge clk);
    endtask

    // Waits a fixed three cycles: one in the source model, one in the selector, one spare.
    task automatic chk_act(input logic [3:0] code);
        cyc(3);
        @(negedge clk);
        check("active code", {28'h0, act_code}, {28'h0, code});
        check("active one-hot", {24'h0, grp_act}, 32'h1 << (code - 4'h1));
        @(posedge clk);
    endtask

    task automatic chk_irq(input logic e);
        @(negedge clk);
        check("irq", {31'h0, irq}, {31'h0, e});
        @(posedge clk);
    endtask

    initial
    begin
        cyc(5000);
        err_total++;
        $display("Error watchdog expected end seen hang");
        give_verdict();
    end

    // ==========================================================
    // Scenarios
    initial
    begin
        cyc(16);
        rst <= 1'b0;
        @(posedge clk);
        rchk(OFS_STATE, 32'hFFFFFFFF, 32'h0000_0101, "state");
        chk_act(4'h1);
        rchk(OFS_CTRL, 32'hFFFFFFFF, 32'h0, "ctrl");
        rchk(OFS_FORCE, 32'hFFFFFFFF, 32'h0, "force");
        rchk(OFS_REMOTE, 32'hFFFFFFFF, 32'h0, "remote");
        rchk(OFS_IRQ_MASK, 32'hFFFFFFFF, 32'h0, "mask");
        rchk(8'h18, 32'hFFFFFFFF, 32'h0, "unmapped");
        wr(OFS_STATE, 32'hFFFFFFFF);
        rchk(OFS_STATE, 32'hFFFFFFFF, 32'h0000_0101, "state read-only");
        $display("Test reset done");

        pulse(8'h04);
        chk_act(4'h1);
        stat(EV_NOCFG_ON);
        stat(EV_NOCFG_OFF);
        wr(OFS_IRQ_STAT, 32'hFF);
        wr(OFS_CTRL, 32'h70);
        cyc(2);
        check("defaults", {24'h0, ld_seen}, 32'hFE);
        rchk(OFS_STATE, 32'hFF00, 32'hFF00, "enabled");
        stat(EV_NEW_GROUPS);
        $display("Test enable done");

        pulse(8'h04);
        chk_act(4'h3);
        cyc(6);
        chk_act(4'h3);
        pulse(8'h28);
        chk_act(4'h4);
        $display("Test pulses done");

        lvl <= 8'h12;
        chk_act(4'h2);
        rchk(OFS_STATE, 32'hFF0000, 32'h120000, "held");
        pulse(8'h04);
        chk_act(4'h2);
        wr(OFS_REMOTE, 32'h3);
        rchk(OFS_REMOTE, 32'hF, 32'h3, "remote choice");
        chk_act(4'h2);
        stat(EV_LOWPRI_ON);
        lvl <= 8'h10;
        chk_act(4'h5);
        wr(OFS_IRQ_STAT, 32'h0C);
        pulse(8'h80);
        chk_act(4'h5);
        stat(EV_LOWPRI_ON);
        stat(EV_LOWPRI_OFF);
        lvl <= 8'h00;
        $display("Test levels done");

        wr(OFS_CTRL, 32'h71);
        pulse(8'h02);
        chk_act(4'h5);
        wr(OFS_FORCE, 32'h7);
        chk_act(4'h7);
        stat(EV_FORCE_OK);
        cyc(4);
        chk_act(4'h7);
        wr(OFS_CTRL, 32'h70);
        chk_act(4'h7);
        wr(OFS_FORCE, 32'h3);
        chk_act(4'h7);
        stat(EV_FORCE_FAIL);
        wr(OFS_CTRL, 32'h71);
        lvl <= 8'h20;
        chk_act(4'h7);
        wr(OFS_CTRL, 32'h70);
        chk_act(4'h6);
        lvl <= 8'h00;
        wr(OFS_CTRL, 32'h11);
        chk_act(4'h1);
        wr(OFS_IRQ_STAT, 32'hFF);
        wr(OFS_FORCE, 32'h4);
        chk_act(4'h1);
        stat(EV_FORCE_FAIL);
        wr(OFS_FORCE, 32'h2);
        chk_act(4'h2);
        wr(OFS_CTRL, 32'h10);
        $display("Test override done");

        wr(OFS_IRQ_STAT, 32'hFF);
        chk_irq(1'b0);
        pulse(8'h01);
        chk_act(4'h1);
        stat(EV_ACT_CHANGE);
        chk_irq(1'b0);
        wr(OFS_IRQ_MASK, 32'h40);
        rchk(OFS_IRQ_MASK, 32'hFFFFFFFF, 32'h40, "mask");
        chk_irq(1'b1);
        wr(OFS_IRQ_STAT, 32'h40);
        chk_irq(1'b0);
        $display("Test interrupt done");
        give_verdict();
    end
endmodule
